// ### verilog/octser_pkg.sv
// constants shared by the eight-channel serializer control and self-test block
// assumes one 125 MHz system clock and an APB master for the register file
// How it works
// - master sleep stops PLL, outputs high-Z
// - channel sleep idles only that channel
// - channel wake keeps PLL, short delay
// - drive enable low puts outputs high-Z
// - drive enable high resumes prior state
// - each channel can send PRBS data
// - activate plus select 0-7 picks channel
// - select 8 runs PRBS on all channels
// - select 9 to F does nothing
// - extest drives and observes link levels
// - at-speed instruction runs PRBS link test
// - result holds pass and complete bits
// - sync held four frames sends sync pattern
// - sync pattern is six ones, six zeros
// - frame is start, ten bits, stop
package octser_pkg;
	localparam int NCH        = 8;
	localparam int DW         = 10;
	localparam int FRAME_BITS = 12;
	localparam logic [3:0] FRAME_LAST = 4'hB;
	localparam logic [2:0] SYNC_HOLD  = 3'h4;
	localparam logic [11:0] SYNC_PATTERN = 12'hFC0;
	localparam logic [3:0] SEL_ALL    = 4'h8;
	// apb map, byte addresses
	localparam logic [11:0] ADDR_CTRL   = 12'h000;
	localparam logic [11:0] ADDR_EXTEST = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;
	localparam int CTRL_START   = 0;
	localparam int CTRL_EXTEST  = 1;
	localparam int STAT_PASS    = 0;
	localparam int STAT_DONE    = 1;
	localparam int STAT_LOCK    = 2;
	localparam int STAT_RUN     = 3;
	localparam int STAT_RLOCK   = 8;
	// timing
	localparam int CLK_NS       = 8;
	localparam int PLL_LOCK_NS  = 2000;
	localparam int WAKE_NS      = 200;
	localparam int TEST_NS      = 33000000;
	localparam logic [15:0] PLL_LOCK_CYC = 16'((PLL_LOCK_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0]  WAKE_CYC     = 8'((WAKE_NS + CLK_NS - 1) / CLK_NS);
	localparam int TEST_CYC     = TEST_NS / CLK_NS;
	// prbs: x^15 + x^14 + 1, must equal the partner checker
	localparam logic [14:0] PRBS_SEED = 15'h7FFF;
	localparam int PRBS_TAP_A   = 14;
	localparam int PRBS_TAP_B   = 13;
	typedef enum logic [1:0] {PLL_OFF, PLL_ACQ, PLL_LOCKED} octser_pll_t;
	typedef enum logic [1:0] {T_IDLE, T_RUN, T_DONE} octser_test_t;
endpackage

// ### verilog/octser_top.sv
// eight-channel 10:1 serializer control: sleep, drive enable, sync, PRBS self-test,
// at-speed link test and extest drive, with an APB register file.
// assumes all pins synchronous to clk; one clk cycle is one serial bit time.
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module octser_top #(
	parameter int TEST_CYCLES = octser_pkg::TEST_CYC
) (
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    reset,
	// apb slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [11:0]             paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	// power and drive control
	input  wire logic                    master_sleep_n,
	input  wire logic [7:0]              channel_sleep_n,
	input  wire logic                    output_drive_enable,
	// self-test pins
	input  wire logic                    selftest_activate,
	input  wire logic [3:0]              selftest_channel_select,
	// data path
	input  wire logic [7:0]              channel_sync_request,
	input  wire logic [7:0][9:0]         parallel_data_in,
	input  wire logic [7:0]              remote_lock_n,
	output logic      [7:0]              serial_out,
	output logic      [7:0]              serial_out_oe_n,
	output logic                         pll_locked
);

	// select decode of the self-test pins, feeds bist_nxt
	function automatic logic [7:0] sel_decode(input logic act, input logic [3:0] sel);
		logic [7:0] m;
		m = 8'h00;
		if (act && sel == octser_pkg::SEL_ALL)
			m = 8'hFF;
		else if (act && sel < octser_pkg::SEL_ALL)
			m = 8'(8'h01 << sel[2:0]);
		return m;
	endfunction

	// ten lfsr steps per frame, low bits sent
	function automatic logic [14:0] prbs_step10(input logic [14:0] s);
		logic [14:0] v;
		v = s;
		for (int i = 0; i < octser_pkg::DW; i++)
			v = {v[13:0], v[octser_pkg::PRBS_TAP_A] ^ v[octser_pkg::PRBS_TAP_B]};
		return v;
	endfunction

	// ---------------- apb and control registers ----------------
	logic [31:0] prdata_r, prdata_nxt;
	logic        pready_r, pready_nxt;
	logic        pslverr_r, pslverr_nxt;
	logic        extest_r, extest_nxt;
	logic [7:0]  ext_drv_r, ext_drv_nxt;
	logic        start_pulse;
	logic        hit;
	octser_pkg::octser_test_t test_r, test_nxt;
	logic [22:0] tcnt_r, tcnt_nxt;
	logic        pass_r, pass_nxt;
	logic [7:0]  rlock_cap_r, rlock_cap_nxt;
	octser_pkg::octser_pll_t pll_r, pll_nxt;
	logic [15:0] pcnt_r, pcnt_nxt;

	assign hit = paddr == octser_pkg::ADDR_CTRL || paddr == octser_pkg::ADDR_EXTEST
		|| paddr == octser_pkg::ADDR_STATUS;

	always_comb begin
		prdata_nxt  = prdata_r;
		pready_nxt  = 1'b0;
		pslverr_nxt = 1'b0;
		extest_nxt  = extest_r;
		ext_drv_nxt = ext_drv_r;
		start_pulse = 1'b0;
		// answer in the first access cycle; read data prepared in setup
		if (psel && !penable) begin
			pready_nxt  = 1'b1;
			pslverr_nxt = !hit;
			prdata_nxt  = 32'h0000_0000;
			case (paddr)
				octser_pkg::ADDR_CTRL:   prdata_nxt[octser_pkg::CTRL_EXTEST] = extest_r;
				octser_pkg::ADDR_EXTEST: prdata_nxt[7:0] = ext_drv_r;
				octser_pkg::ADDR_STATUS: begin
					prdata_nxt[octser_pkg::STAT_PASS] = pass_r;
					prdata_nxt[octser_pkg::STAT_DONE] = test_r == octser_pkg::T_DONE;
					prdata_nxt[octser_pkg::STAT_LOCK] = pll_r == octser_pkg::PLL_LOCKED;
					prdata_nxt[octser_pkg::STAT_RUN]  = test_r == octser_pkg::T_RUN;
					prdata_nxt[octser_pkg::STAT_RLOCK +: 8] = rlock_cap_r;
				end
				default: prdata_nxt = 32'h0000_0000;
			endcase
		end
		if (psel && penable && pready_r && pwrite) begin
			case (paddr)
				octser_pkg::ADDR_CTRL: begin
					extest_nxt  = pwdata[octser_pkg::CTRL_EXTEST];
					start_pulse = pwdata[octser_pkg::CTRL_START];
				end
				octser_pkg::ADDR_EXTEST: ext_drv_nxt = pwdata[7:0];
				default: ext_drv_nxt = ext_drv_r;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			prdata_r  <= 32'h0000_0000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			extest_r  <= 1'b0;
			ext_drv_r <= 8'h00;
		end else begin
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			extest_r  <= extest_nxt;
			ext_drv_r <= ext_drv_nxt;
		end
	end

	// ---------------- shared pll and frame strobes ----------------
	logic [3:0] bit_r, bit_nxt;
	logic       frame_tick;
	assign frame_tick = pll_r == octser_pkg::PLL_LOCKED && bit_r == octser_pkg::FRAME_LAST;

	always_comb begin
		pll_nxt  = pll_r;
		pcnt_nxt = pcnt_r;
		bit_nxt  = bit_r;
		if (!master_sleep_n) begin
			pll_nxt  = octser_pkg::PLL_OFF;
			pcnt_nxt = 16'h0000;
		end else begin
			case (pll_r)
				octser_pkg::PLL_OFF: pll_nxt = octser_pkg::PLL_ACQ;
				octser_pkg::PLL_ACQ: begin
					pcnt_nxt = pcnt_r + 16'h0001;
					if (pcnt_r == octser_pkg::PLL_LOCK_CYC)
						pll_nxt = octser_pkg::PLL_LOCKED;
				end
				octser_pkg::PLL_LOCKED: pll_nxt = octser_pkg::PLL_LOCKED;
				default: pll_nxt = octser_pkg::PLL_OFF;
			endcase
		end
		if (pll_r != octser_pkg::PLL_LOCKED)
			bit_nxt = 4'h0;
		else if (bit_r == octser_pkg::FRAME_LAST)
			bit_nxt = 4'h0;
		else
			bit_nxt = bit_r + 4'h1;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pll_r  <= octser_pkg::PLL_OFF;
			pcnt_r <= 16'h0000;
			bit_r  <= 4'h0;
		end else begin
			pll_r  <= pll_nxt;
			pcnt_r <= pcnt_nxt;
			bit_r  <= bit_nxt;
		end
	end

	// ---------------- at-speed link test ----------------
	// lock loss on any channel during the run counts as a failed link;
	// the partner checker owns the exact error count
	always_comb begin
		test_nxt      = test_r;
		tcnt_nxt      = tcnt_r;
		pass_nxt      = pass_r;
		rlock_cap_nxt = rlock_cap_r;
		if (extest_r)
			rlock_cap_nxt = ~remote_lock_n;
		case (test_r)
			octser_pkg::T_IDLE, octser_pkg::T_DONE: begin
				// start runs prbs at system rate
				if (start_pulse && pll_r == octser_pkg::PLL_LOCKED) begin
					test_nxt = octser_pkg::T_RUN;
					tcnt_nxt = 23'h000000;
					pass_nxt = 1'b1;
				end
			end
			octser_pkg::T_RUN: begin
				tcnt_nxt = tcnt_r + 23'h000001;
				if (|remote_lock_n || pll_r != octser_pkg::PLL_LOCKED)
					pass_nxt = 1'b0;
				if (tcnt_r == 23'(TEST_CYCLES - 1))
					test_nxt = octser_pkg::T_DONE;
			end
			default: test_nxt = octser_pkg::T_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			test_r      <= octser_pkg::T_IDLE;
			tcnt_r      <= 23'h000000;
			pass_r      <= 1'b0;
			rlock_cap_r <= 8'h00;
		end else begin
			test_r      <= test_nxt;
			tcnt_r      <= tcnt_nxt;
			pass_r      <= pass_nxt;
			rlock_cap_r <= rlock_cap_nxt;
		end
	end

	// ---------------- per-channel serializers ----------------
	logic [7:0] bist_r, bist_nxt;
	// one channel, all, none for 9 to F; all channels while the link test runs
	assign bist_nxt = sel_decode(selftest_activate, selftest_channel_select)
		| {8{test_r == octser_pkg::T_RUN}};

	logic [7:0]  out_r, oe_n_r;
	logic        out_nxt [8], oe_n_nxt [8];
	logic [11:0] shift_r [8];
	logic [11:0] shift_nxt [8];
	logic [14:0] lfsr_r [8];
	logic [14:0] lfsr_nxt [8];
	logic [2:0]  sync_r [8];
	logic [2:0]  sync_nxt [8];
	logic [7:0]  wake_r [8];
	logic [7:0]  wake_nxt [8];

	generate
		for (genvar c = 0; c < octser_pkg::NCH; c++) begin : g_ch
			always_comb begin
				shift_nxt[c] = shift_r[c];
				lfsr_nxt[c]  = lfsr_r[c];
				sync_nxt[c]  = sync_r[c];
				wake_nxt[c]  = wake_r[c];
				// channel sleep, short wake without pll relock
				if (!channel_sleep_n[c])
					wake_nxt[c] = octser_pkg::WAKE_CYC;
				else if (wake_r[c] != 8'h00 && pll_r == octser_pkg::PLL_LOCKED)
					wake_nxt[c] = wake_r[c] - 8'h01;
				if (pll_r != octser_pkg::PLL_LOCKED) begin
					shift_nxt[c] = 12'h000;
					sync_nxt[c]  = 3'h0;
				end else if (frame_tick) begin
					if (!channel_sync_request[c])
						sync_nxt[c] = 3'h0;
					else if (sync_r[c] != octser_pkg::SYNC_HOLD)
						sync_nxt[c] = sync_r[c] + 3'h1;
					if (sync_nxt[c] == octser_pkg::SYNC_HOLD) begin
						shift_nxt[c] = octser_pkg::SYNC_PATTERN;
					end else if (bist_r[c]) begin
						lfsr_nxt[c]  = prbs_step10(lfsr_r[c]);
						shift_nxt[c] = {1'b1, lfsr_nxt[c][9:0], 1'b0};
					end else begin
						shift_nxt[c] = {1'b1, parallel_data_in[c], 1'b0};
					end
				end else begin
					shift_nxt[c] = {shift_r[c][10:0], 1'b0};
				end
				// drive enable gates all; state kept meanwhile
				out_nxt[c]  = extest_r ? ext_drv_r[c] : shift_nxt[c][11];
				oe_n_nxt[c] = !(master_sleep_n && output_drive_enable && channel_sleep_n[c]
					&& pll_r == octser_pkg::PLL_LOCKED && wake_r[c] == 8'h00);
			end

			always_ff @(posedge clk) begin
				if (reset) begin
					shift_r[c] <= 12'h000;
					lfsr_r[c]  <= octser_pkg::PRBS_SEED;
					sync_r[c]  <= 3'h0;
					wake_r[c]  <= octser_pkg::WAKE_CYC;
				end else begin
					shift_r[c] <= shift_nxt[c];
					lfsr_r[c]  <= lfsr_nxt[c];
					sync_r[c]  <= sync_nxt[c];
					wake_r[c]  <= wake_nxt[c];
				end
			end
		end
	endgenerate

	logic pll_locked_r;
	always_ff @(posedge clk) begin
		if (reset) begin
			out_r        <= 8'h00;
			oe_n_r       <= 8'hFF;
			bist_r       <= 8'h00;
			pll_locked_r <= 1'b0;
		end else begin
			out_r        <= {<<{out_nxt}};
			oe_n_r       <= {<<{oe_n_nxt}};
			bist_r       <= bist_nxt;
			pll_locked_r <= pll_nxt == octser_pkg::PLL_LOCKED;
		end
	end

	assign prdata          = prdata_r;
	assign pready          = pready_r;
	assign pslverr         = pslverr_r;
	assign serial_out      = out_r;
	assign serial_out_oe_n = oe_n_r;
	assign pll_locked      = pll_locked_r;

	// ---------------- assertions ----------------
	property p_sleep_hiz;
		@(posedge clk) disable iff (reset)
		!master_sleep_n |=> serial_out_oe_n == 8'hFF && !pll_locked;
	endproperty
	a_sleep_hiz: assert property (p_sleep_hiz) else $error("outputs driven in master sleep");

	property p_chan_sleep;
		@(posedge clk) disable iff (reset)
		!channel_sleep_n[0] |=> serial_out_oe_n[0];
	endproperty
	a_chan_sleep: assert property (p_chan_sleep) else $error("sleeping channel drives");

	property p_wake_keeps_pll;
		@(posedge clk) disable iff (reset)
		$rose(channel_sleep_n[0]) && pll_locked && master_sleep_n |=> pll_locked;
	endproperty
	a_wake_keeps_pll: assert property (p_wake_keeps_pll) else $error("channel wake lost pll");

	property p_den_hiz;
		@(posedge clk) disable iff (reset)
		!output_drive_enable |=> serial_out_oe_n == 8'hFF;
	endproperty
	a_den_hiz: assert property (p_den_hiz) else $error("driving with enable low");

	property p_sel_one;
		@(posedge clk) disable iff (reset)
		selftest_activate && selftest_channel_select == 4'h3 && test_r == octser_pkg::T_IDLE |=> bist_r == 8'h08;
	endproperty
	a_sel_one: assert property (p_sel_one) else $error("wrong channel in self-test");

	property p_sel_all;
		@(posedge clk) disable iff (reset)
		selftest_activate && selftest_channel_select == 4'h8 |=> bist_r == 8'hFF;
	endproperty
	a_sel_all: assert property (p_sel_all) else $error("select 8 not all channels");

	property p_sel_none;
		@(posedge clk) disable iff (reset)
		selftest_channel_select > 4'h8 && test_r == octser_pkg::T_IDLE |=> bist_r == 8'h00;
	endproperty
	a_sel_none: assert property (p_sel_none) else $error("self-test on reserved select");

	sequence s_sync_loaded;
		shift_r[0] == octser_pkg::SYNC_PATTERN;
	endsequence
	property p_sync;
		@(posedge clk) disable iff (reset)
		frame_tick && channel_sync_request[0] && sync_r[0] == 3'h3 |=> s_sync_loaded;
	endproperty
	a_sync: assert property (p_sync) else $error("sync pattern not sent");

	property p_frame;
		@(posedge clk) disable iff (reset)
		frame_tick && !channel_sync_request[0] |=> shift_r[0][11] && !shift_r[0][0];
	endproperty
	a_frame: assert property (p_frame) else $error("frame bits missing");

	property p_done;
		@(posedge clk) disable iff (reset)
		test_r == octser_pkg::T_RUN && tcnt_r == 23'(TEST_CYCLES - 1) |=> test_r == octser_pkg::T_DONE;
	endproperty
	a_done: assert property (p_done) else $error("test did not complete");

endmodule // octser_top

// ### verif/octser_remote_rx.sv
// model of the eight remote deserializers, lock indication only
// assumes one serial bit per clk; lock_n high until a driven one is seen, and again after 24 clk without one
`timescale 1ns/1ps
module octser_remote_rx (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// serial side
	input  wire logic [7:0] serial_out,
	input  wire logic [7:0] serial_out_oe_n,
	output logic      [7:0] remote_lock_n
);
	logic [4:0] gap_r [8];
	always @(posedge clk) begin
		for (int c = 0; c < 8; c++) begin
			if (reset)
				gap_r[c] <= 5'h18;
			else if (!serial_out_oe_n[c] && serial_out[c])
				gap_r[c] <= 5'h00;
			else if (gap_r[c] != 5'h18)
				gap_r[c] <= gap_r[c] + 5'h01;
			remote_lock_n[c] <= (gap_r[c] == 5'h18);
		end
	end
endmodule // octser_remote_rx

// ### verif/testbench.sv
// bench for octser_top: pins, frames and APB registers
// assumes octser_remote_rx on the links, its lock fed back to sync
`timescale 1ns/1ps
module testbench;
	logic            clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0]     paddr = 12'h000;
	logic [31:0]     pwdata = 32'h0, prdata, r;
	logic            pready, pslverr, pll_locked, e;
	logic            master_sleep_n = 1'b1, output_drive_enable = 1'b1, selftest_activate = 1'b0;
	logic [3:0]      selftest_channel_select = 4'hF, ph = 4'h0;
	logic [7:0]      channel_sleep_n = 8'hFF, sync_tb = 8'h00, prev;
	logic [7:0]      remote_lock_n, serial_out, serial_out_oe_n, channel_sync_request;
	logic [7:0][9:0] parallel_data_in = '0;
	logic [11:0]     fr [8];
	int              err_total = 0, compares = 0, n, c;

	always #4 clk = ~clk;
	always @(posedge clk) ph <= (ph == 4'hB) ? 4'h0 : ph + 4'h1;
	assign channel_sync_request = sync_tb | remote_lock_n;

	octser_top #(.TEST_CYCLES(200)) dut (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .master_sleep_n, .channel_sleep_n, .output_drive_enable,
		.selftest_activate, .selftest_channel_select, .channel_sync_request, .parallel_data_in,
		.remote_lock_n, .serial_out, .serial_out_oe_n, .pll_locked);
	octser_remote_rx rx (.clk, .reset, .serial_out, .serial_out_oe_n, .remote_lock_n);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		chk(32'(pready), 32'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// one whole frame of every channel, start bit first
	task automatic grab;
		do @(negedge clk); while (ph != 4'h0);
		for (int i = 11; i >= 0; i--) begin
			for (int j = 0; j < 8; j++) fr[j][i] = serial_out[j];
			if (i > 0) @(negedge clk);
		end
	endtask

	task automatic give_verdict;
		$display("comparisons %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		for (n = 0; n < 400 && pll_locked !== 1'b1; n++) @(negedge clk);
		for (n = 0; n < 100 && serial_out_oe_n !== 8'h00; n++) @(negedge clk);
		chk(serial_out_oe_n, 8'h00);
		repeat (100) @(negedge clk);
		// channel 7 still sends zeros: its rising edge marks frame start
		do begin
			prev = serial_out;
			@(negedge clk);
		end while (!(serial_out[7] && !prev[7]));
		ph = 4'h0;
		@(posedge clk);
		for (c = 0; c < 8; c++) parallel_data_in[c] <= 10'h2C9 + 10'(c);
		grab;
		grab;
		for (c = 0; c < 8; c++) chk(fr[c], {1'b1, parallel_data_in[c], 1'b0});
		for (n = 0; n < 17; n++) begin
			@(posedge clk);
			selftest_activate <= (n < 16);
			selftest_channel_select <= 4'(n);
			grab;
			grab;
			for (c = 0; c < 8; c++)
				if (n == c || n == 8)
					chk({fr[c][11], fr[c][0], fr[c][10:1] != parallel_data_in[c]}, 3'h5);
				else
					chk(fr[c], {1'b1, parallel_data_in[c], 1'b0});
		end
		grab;
		repeat (2) @(posedge clk);
		sync_tb[1] <= 1'b1;
		for (n = 1; n < 6; n++) begin
			grab;
			chk(fr[1], n > 3 ? 12'hFC0 : {1'b1, parallel_data_in[1], 1'b0});
		end
		@(posedge clk);
		sync_tb[1] <= 1'b0;
		grab;
		grab;
		chk(fr[1], {1'b1, parallel_data_in[1], 1'b0});
		@(posedge clk);
		output_drive_enable <= 1'b0;
		repeat (3) @(negedge clk);
		chk(serial_out_oe_n, 8'hFF);
		@(posedge clk);
		output_drive_enable <= 1'b1;
		repeat (3) @(negedge clk);
		chk(serial_out_oe_n, 8'h00);
		grab;
		chk(fr[0], {1'b1, parallel_data_in[0], 1'b0});
		apb(1'b0, 12'h008, 32'h0);
		chk(r, 32'h4);
		apb(1'b0, 12'h00C, 32'h0);
		chk({e, r[30:0]}, 32'h80000000);
		apb(1'b1, 12'h000, 32'h1);
		apb(1'b0, 12'h008, 32'h0);
		chk(r[3], 1'b1);
		for (n = 0; n < 150 && r[1] !== 1'b1; n++) apb(1'b0, 12'h008, 32'h0);
		chk(r[1:0], 2'h3);
		apb(1'b0, 12'h000, 32'h0);
		chk(r, 32'h0);
		apb(1'b1, 12'h000, 32'h1);
		channel_sleep_n[3] <= 1'b0;
		apb(1'b0, 12'h008, 32'h0);
		for (n = 0; n < 150 && r[1] !== 1'b1; n++) apb(1'b0, 12'h008, 32'h0);
		chk(r[1:0], 2'h2);
		channel_sleep_n[3] <= 1'b1;
		repeat (60) @(posedge clk);
		apb(1'b1, 12'h004, 32'h5A);
		apb(1'b1, 12'h000, 32'h2);
		repeat (3) @(negedge clk);
		chk(serial_out, 8'h5A);
		apb(1'b0, 12'h008, 32'h0);
		chk(r, 32'h0000FF06);
		apb(1'b0, 12'h004, 32'h0);
		chk(r, 32'h5A);
		apb(1'b1, 12'h000, 32'h0);
		channel_sleep_n[2] <= 1'b0;
		repeat (3) @(negedge clk);
		chk({pll_locked, serial_out_oe_n}, 9'h104);
		@(posedge clk);
		channel_sleep_n[2] <= 1'b1;
		repeat (20) @(negedge clk);
		chk(serial_out_oe_n[2], 1'b1);
		for (n = 0; n < 40 && serial_out_oe_n[2] !== 1'b0; n++) @(negedge clk);
		chk({pll_locked, serial_out_oe_n}, 9'h100);
		@(posedge clk);
		master_sleep_n <= 1'b0;
		repeat (30) @(negedge clk);
		chk({pll_locked, serial_out_oe_n, remote_lock_n}, 17'h0FFFF);
		@(posedge clk);
		master_sleep_n <= 1'b1;
		for (n = 0; n < 600 && remote_lock_n !== 8'h00; n++) @(negedge clk);
		chk({pll_locked, serial_out_oe_n, remote_lock_n}, 17'h10000);
		give_verdict;
	end

	initial begin
		#400000;
		err_total++;
		give_verdict;
	end
endmodule // testbench
